/* File: common/rcb_pkg.sv */
// Package with register map, field positions, timing counts and carrier types of the reset-cause block.
package rcb_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CAUSE = 8'hA2;
  localparam logic [7:0] ADDR_BOD = 8'hA3;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hB0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hB1;

  // ==========================================================
  // Field positions of reset_cause_flags
  localparam int CAUSE_SOFT_BIT = 7;
  localparam int CAUSE_PIN_BIT = 6;
  localparam int CAUSE_HARD_BIT = 5;
  localparam int CAUSE_GP_BIT = 3;

  // ==========================================================
  // Field positions of brownout_control and config_byte_two
  localparam int BOD_EN_BIT = 7;
  localparam int BOD_THR_MSB = 6;
  localparam int BOD_THR_LSB = 4;
  localparam int BOD_FLAG_BIT = 3;
  localparam int BOD_RSTEN_BIT = 2;
  localparam int BOD_RSTF_BIT = 1;
  localparam int BOD_STAT_BIT = 0;

  // ==========================================================
  // Interrupt status and mask layout
  localparam int EVT_W = 5;
  localparam int EVT_SOFT = 0;
  localparam int EVT_PIN = 1;
  localparam int EVT_HARD = 2;
  localparam int EVT_CROSS = 3;
  localparam int EVT_BOR = 4;

  // ==========================================================
  // Reset values and timing counts
  localparam logic [EVT_W-1:0] IRQ_MASK_RESET = 5'h00;
  localparam logic [EVT_W-1:0] IRQ_STATUS_RESET = 5'h00;
  localparam logic [1:0] BOD_SETTLE_TICKS = 2'h3;

  // ==========================================================
  // Detection level codes of the threshold field
  typedef enum logic [1:0] {
    RCB_LVL_4V4 = 2'b00,
    RCB_LVL_3V7 = 2'b01,
    RCB_LVL_2V7 = 2'b10,
    RCB_LVL_2V2 = 2'b11
  } rcb_level_t;

  // ==========================================================
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rcb_bus_req_t;

endpackage

/* File: dv/rcb_ctrl_asserts.sv */
// Checker of the port behaviour of the reset-cause and brown-out block.
`timescale 1ns/10ps
module rcb_ctrl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire rcb_pkg::rcb_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  // Reset sources
  input wire logic chip_reset,
  input wire logic soft_reset_evt,
  input wire logic reset_pin_active,
  input wire logic pc_overflow,
  input wire logic debug_mode,
  input wire logic debug_reset_enable,
  input wire logic hard_fault_reset_req,
  input wire logic brownout_reset_req,
  // Configuration and enables
  input wire logic [7:0] config_byte_two,
  input wire logic brownout_irq_enable,
  input wire logic global_irq_enable,
  // Detector
  input wire logic low_speed_internal_osc,
  input wire logic brownout_below,
  input wire logic brownout_detector_enable,
  input wire logic [1:0] brownout_threshold_select,
  // Interrupts
  input wire logic brownout_irq,
  input wire logic irq
);
  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_hard_req: assert property (pc_overflow && !(debug_mode && !debug_reset_enable) |=> hard_fault_reset_req)
    else $error("hard fault reset not requested");
  chk_hard_block: assert property (pc_overflow && debug_mode && !debug_reset_enable |=> !hard_fault_reset_req)
    else $error("hard fault reset not suppressed");
  chk_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property (bus_req.rd && !(bus_req.addr inside {8'hA2, 8'hA3, 8'hB0, 8'hB1}) |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_status_off: assert property (bus_req.rd && bus_req.addr == rcb_pkg::ADDR_BOD && !brownout_detector_enable |=> !bus_rdata[0])
    else $error("live status set while detector off");
  chk_bor_enable: assert property (brownout_reset_req |-> $past(brownout_detector_enable))
    else $error("brown-out reset while detector off");
  chk_bod_irq: assert property (brownout_irq |-> $past(brownout_irq_enable && global_irq_enable))
    else $error("brown-out interrupt without both enables");
  chk_cfg_reload: assert property ($rose(rst_b) || chip_reset |=> brownout_detector_enable == $past(config_byte_two[7]) && brownout_threshold_select == $past(config_byte_two[5:4]))
    else $error("configuration fields not reloaded");
endmodule
bind rcb_ctrl rcb_ctrl_chk u_chk (.*);

/* File: dv/tb_rcb_ctrl.sv */
// Self-checking testbench of the reset-cause and brown-out block.
`timescale 1ns/10ps
`define CHK(nm, e, v) begin n_compared++; if ((v) !== (e)) begin failures++; $display("wrong value %s exp %0h got %0h", nm, e, v); end end
module tb_rcb_ctrl;
  logic clk = 1'b0, rst_b = 1'b0, chip_reset = 1'b0, soft_reset_evt = 1'b0, reset_pin_active = 1'b0;
  logic pc_overflow = 1'b0, debug_mode = 1'b0, debug_reset_enable = 1'b0, hard_fault_reset_req;
  logic brownout_reset_req, brownout_irq_enable = 1'b0, global_irq_enable = 1'b0;
  logic low_speed_internal_osc = 1'b0, brownout_below = 1'b0, brownout_detector_enable, brownout_irq, irq;
  logic [7:0] config_byte_two = 8'h54, bus_rdata;
  logic [1:0] brownout_threshold_select;
  rcb_pkg::rcb_bus_req_t bus_req = '0;
  int failures = 0, n_compared = 0, cycles = 0;
  rcb_ctrl u_dut (.*);
  // ==========================================================
  // Clocks and watchdog
  initial forever #20 clk = ~clk;
  // The slow oscillator is unrelated to clk, so settling is seen across a real sync.
  initial forever #203 low_speed_internal_osc = ~low_speed_internal_osc;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      stop_test();
    end
  end
  // ==========================================================
  // Tasks
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    `CHK("read data", e, bus_rdata & m)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    cyc(20);
    rst_b <= 1'b1;
    cyc(3);
    rd(8'hA2, 8'hFF, 8'h00);
    rd(8'hA3, 8'hFF, 8'h54);
    `CHK("threshold", 2'b01, brownout_threshold_select)
    wr(8'hA2, 8'h08);
    rd(8'hA2, 8'hFF, 8'h08);
    wr(8'hA2, 8'h00);
    @(posedge clk) soft_reset_evt <= 1'b1;
    @(posedge clk) soft_reset_evt <= 1'b0;
    rd(8'hA2, 8'hFF, 8'h80);
    @(posedge clk) reset_pin_active <= 1'b1;
    cyc(6);
    rd(8'hA2, 8'hFF, 8'hC0);
    @(posedge clk) pc_overflow <= 1'b1;
    @(posedge clk) pc_overflow <= 1'b0;
    #1 `CHK("hard fault request", 1'b1, hard_fault_reset_req)
    rd(8'hA2, 8'hFF, 8'hE0);
    wr(8'hA3, 8'h00);
    @(posedge clk) chip_reset <= 1'b1;
    @(posedge clk) chip_reset <= 1'b0;
    rd(8'hA2, 8'hFF, 8'hE0);
    rd(8'hA3, 8'hFF, 8'h54);
    wr(8'hA2, 8'h00);
    debug_mode <= 1'b1;
    @(posedge clk) pc_overflow <= 1'b1;
    @(posedge clk) pc_overflow <= 1'b0;
    #1 `CHK("hard fault request", 1'b0, hard_fault_reset_req)
    rd(8'hA2, 8'hFF, 8'h20);
    for (int i = 0; i < 4; i++) begin
      wr(8'hA3, {2'b00, i[1:0], 4'h0});
      #1 `CHK("threshold", i[1:0], brownout_threshold_select)
    end
    brownout_below <= 1'b1;
    wr(8'hA3, 8'h84);
    rd(8'hA3, 8'hF7, 8'h84);
    cyc(60);
    `CHK("brown-out reset", 1'b1, brownout_reset_req)
    rd(8'hA3, 8'hF7, 8'h87);
    brownout_below <= 1'b0;
    cyc(10);
    `CHK("brown-out reset", 1'b0, brownout_reset_req)
    rd(8'hA3, 8'hFF, 8'h8E);
    brownout_irq_enable <= 1'b1;
    cyc(3);
    `CHK("brown-out irq", 1'b0, brownout_irq)
    global_irq_enable <= 1'b1;
    cyc(3);
    `CHK("brown-out irq", 1'b1, brownout_irq)
    wr(8'hA3, 8'h84);
    rd(8'hA3, 8'hFF, 8'h84);
    wr(8'hA3, 8'h80);
    brownout_below <= 1'b1;
    cyc(10);
    `CHK("brown-out reset", 1'b0, brownout_reset_req)
    rd(8'hA3, 8'hF7, 8'h81);
    wr(8'hA3, 8'h00);
    cyc(10);
    rd(8'hA3, 8'hF7, 8'h00);
    rd(8'hB0, 8'hFF, 8'h1F);
    `CHK("irq", 1'b0, irq)
    wr(8'hB1, 8'h01);
    cyc(2);
    `CHK("irq", 1'b1, irq)
    wr(8'hB0, 8'h1F);
    rd(8'hB0, 8'hFF, 8'h00);
    `CHK("irq", 1'b0, irq)
    rd(8'h55, 8'hFF, 8'h00);
    stop_test();
  end
endmodule

/* File: rtl/rcb_ctrl.sv */
// Reset cause flags and brown-out detector control with register port and interrupt.
//
// Functional notes
// - A software reset event sets the software reset cause flag at bit 7 of reset_cause_flags.
// - A reset through the external pin sets the pin reset cause flag at bit 6.
// - A program counter past the flash size sets the hard fault flag, bit 5, and requests a reset unless debug_mode is set without debug_reset_enable.
// - Bit 3 of reset_cause_flags is a general purpose flag with no hardware effect.
// - The detector output is ignored until enough slow oscillator clocks pass after enabling.
// - Threshold code 11 is 2.2V, 10 is 2.7V, 01 is 3.7V and 00 is 4.4V.
// - Any supply crossing while the detector is enabled and settled sets the brown-out event flag; its request needs both enables.
// - With brown-out reset enable high a supply below threshold requests a device reset.
// - A brown-out caused reset sets the brown-out reset cause flag at bit 1.
// - Read-only live status is 1 only while enabled, valid and below threshold.
// - After every reset enable, threshold and reset enable reload from config_byte_two.
//
// Local design decision: strobed register access.
`timescale 1ns/10ps

module rcb_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire rcb_pkg::rcb_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // Reset sources and reset controller
  input wire logic chip_reset,
  input wire logic soft_reset_evt,
  input wire logic reset_pin_active,
  input wire logic pc_overflow,
  input wire logic debug_mode,
  input wire logic debug_reset_enable,
  output logic hard_fault_reset_req,
  output logic brownout_reset_req,
  // Configuration and interrupt enables
  input wire logic [7:0] config_byte_two,
  input wire logic brownout_irq_enable,
  input wire logic global_irq_enable,
  // Analog detector
  input wire logic low_speed_internal_osc,
  input wire logic brownout_below,
  output logic brownout_detector_enable,
  output logic [1:0] brownout_threshold_select,
  // Interrupts
  output logic brownout_irq,
  output logic irq
);

  typedef struct packed {
    logic loaded;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic below_meta;
    logic below_sync;
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic [1:0] settle_cnt;
    logic valid_q;
    logic soft_reset_cause_flag;
    logic pin_reset_cause_flag;
    logic hard_fault_cause_flag;
    logic general_flag_two;
    logic bod_en;
    logic [2:0] thr;
    logic brownout_event_flag;
    logic brownout_reset_enable;
    logic brownout_reset_cause_flag;
    logic brownout_live_status;
    logic [rcb_pkg::EVT_W-1:0] irq_status;
    logic [rcb_pkg::EVT_W-1:0] irq_mask;
    logic [7:0] rdata;
    logic hf_req;
    logic bo_req;
    logic bo_irq;
    logic irq;
  } rcb_state_t;

  rcb_state_t s;
  rcb_state_t next_s;
  logic pin_event;
  logic osc_tick;
  logic valid;
  logic crossing;
  logic bo_fire;
  logic hf_reset;
  logic wr_cause;
  logic wr_bod;
  logic [rcb_pkg::EVT_W-1:0] events;
  logic [7:0] cause_rd;
  logic [7:0] bod_rd;

  always_comb begin
    next_s = s;
    // ========================================================
    // Synchronisers for pin, comparator and slow oscillator
    next_s.pin_meta = reset_pin_active;
    next_s.pin_sync = s.pin_meta;
    next_s.pin_prev = s.pin_sync;
    next_s.below_meta = brownout_below;
    next_s.below_sync = s.below_meta;
    next_s.osc_meta = low_speed_internal_osc;
    next_s.osc_sync = s.osc_meta;
    next_s.osc_prev = s.osc_sync;
    pin_event = s.pin_sync & ~s.pin_prev;
    osc_tick = s.osc_sync & ~s.osc_prev;

    // ========================================================
    // Detector settling and live status
    // settle count after enable
    if (!s.bod_en) begin
      next_s.settle_cnt = 2'h0;
    end else if (osc_tick && s.settle_cnt != rcb_pkg::BOD_SETTLE_TICKS) begin
      next_s.settle_cnt = s.settle_cnt + 2'h1;
    end
    valid = s.bod_en && (s.settle_cnt == rcb_pkg::BOD_SETTLE_TICKS);
    next_s.valid_q = valid;
    next_s.brownout_live_status = valid & s.below_sync;
    crossing = valid && s.valid_q && (s.below_sync != s.brownout_live_status);
    // drop below threshold resets only when enabled
    bo_fire = valid && s.below_sync && s.brownout_reset_enable;
    // debug mode suppresses the hard fault reset unless debug_reset_enable is set
    hf_reset = pc_overflow && !(debug_mode && !debug_reset_enable);

    // ========================================================
    // Software writes, then hardware sets win over them
    wr_cause = bus_req.wr && (bus_req.addr == rcb_pkg::ADDR_CAUSE);
    wr_bod = bus_req.wr && (bus_req.addr == rcb_pkg::ADDR_BOD);
    // flags change only by software or by their cause
    if (wr_cause) begin
      next_s.soft_reset_cause_flag = bus_req.wdata[rcb_pkg::CAUSE_SOFT_BIT];
      next_s.pin_reset_cause_flag = bus_req.wdata[rcb_pkg::CAUSE_PIN_BIT];
      next_s.hard_fault_cause_flag = bus_req.wdata[rcb_pkg::CAUSE_HARD_BIT];
      next_s.general_flag_two = bus_req.wdata[rcb_pkg::CAUSE_GP_BIT];
    end
    if (wr_bod) begin
      next_s.bod_en = bus_req.wdata[rcb_pkg::BOD_EN_BIT];
      next_s.thr = bus_req.wdata[rcb_pkg::BOD_THR_MSB:rcb_pkg::BOD_THR_LSB];
      next_s.brownout_event_flag = bus_req.wdata[rcb_pkg::BOD_FLAG_BIT];
      next_s.brownout_reset_enable = bus_req.wdata[rcb_pkg::BOD_RSTEN_BIT];
      next_s.brownout_reset_cause_flag = bus_req.wdata[rcb_pkg::BOD_RSTF_BIT];
    end
    if (soft_reset_evt) begin
      next_s.soft_reset_cause_flag = 1'b1;
    end
    if (pin_event) begin
      next_s.pin_reset_cause_flag = 1'b1;
    end
    if (pc_overflow) begin
      next_s.hard_fault_cause_flag = 1'b1;
    end
    if (crossing) begin
      next_s.brownout_event_flag = 1'b1;
    end
    if (bo_fire) begin
      next_s.brownout_reset_cause_flag = 1'b1;
    end

    // ========================================================
    // Reload from the configuration byte after every reset
    // reload overrides a write in the same cycle
    next_s.loaded = 1'b1;
    if (!s.loaded || chip_reset) begin
      next_s.bod_en = config_byte_two[rcb_pkg::BOD_EN_BIT];
      next_s.thr = config_byte_two[rcb_pkg::BOD_THR_MSB:rcb_pkg::BOD_THR_LSB];
      next_s.brownout_reset_enable = config_byte_two[rcb_pkg::BOD_RSTEN_BIT];
      next_s.settle_cnt = 2'h0;
    end

    // ========================================================
    // Interrupt status, mask and outputs
    events = '0;
    events[rcb_pkg::EVT_SOFT] = soft_reset_evt;
    events[rcb_pkg::EVT_PIN] = pin_event;
    events[rcb_pkg::EVT_HARD] = pc_overflow;
    events[rcb_pkg::EVT_CROSS] = crossing;
    events[rcb_pkg::EVT_BOR] = bo_fire;
    // A set in the clearing cycle survives, so no event is lost.
    if (bus_req.wr && bus_req.addr == rcb_pkg::ADDR_IRQ_STATUS) begin
      next_s.irq_status = s.irq_status & ~bus_req.wdata[rcb_pkg::EVT_W-1:0];
    end
    next_s.irq_status = next_s.irq_status | events;
    if (bus_req.wr && bus_req.addr == rcb_pkg::ADDR_IRQ_MASK) begin
      next_s.irq_mask = bus_req.wdata[rcb_pkg::EVT_W-1:0];
    end
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
    next_s.bo_irq = next_s.brownout_event_flag & brownout_irq_enable & global_irq_enable;
    next_s.hf_req = hf_reset;
    next_s.bo_req = bo_fire;

    // ========================================================
    // Read data, one cycle after the strobe
    cause_rd = 8'h00;
    cause_rd[rcb_pkg::CAUSE_SOFT_BIT] = s.soft_reset_cause_flag;
    cause_rd[rcb_pkg::CAUSE_PIN_BIT] = s.pin_reset_cause_flag;
    cause_rd[rcb_pkg::CAUSE_HARD_BIT] = s.hard_fault_cause_flag;
    cause_rd[rcb_pkg::CAUSE_GP_BIT] = s.general_flag_two;
    bod_rd = 8'h00;
    bod_rd[rcb_pkg::BOD_EN_BIT] = s.bod_en;
    bod_rd[rcb_pkg::BOD_THR_MSB:rcb_pkg::BOD_THR_LSB] = s.thr;
    bod_rd[rcb_pkg::BOD_FLAG_BIT] = s.brownout_event_flag;
    bod_rd[rcb_pkg::BOD_RSTEN_BIT] = s.brownout_reset_enable;
    bod_rd[rcb_pkg::BOD_RSTF_BIT] = s.brownout_reset_cause_flag;
    bod_rd[rcb_pkg::BOD_STAT_BIT] = s.brownout_live_status;
    next_s.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        rcb_pkg::ADDR_CAUSE: begin
          next_s.rdata = cause_rd;
        end
        rcb_pkg::ADDR_BOD: begin
          next_s.rdata = bod_rd;
        end
        rcb_pkg::ADDR_IRQ_STATUS: begin
          next_s.rdata = {3'h0, s.irq_status};
        end
        rcb_pkg::ADDR_IRQ_MASK: begin
          next_s.rdata = {3'h0, s.irq_mask};
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  // Power-on reset clears everything; the configuration reload follows one edge later.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign bus_rdata = s.rdata;
  assign hard_fault_reset_req = s.hf_req;
  assign brownout_reset_req = s.bo_req;
  assign brownout_detector_enable = s.bod_en;
  // low two bits of the field pick the level
  assign brownout_threshold_select = s.thr[1:0];
  assign brownout_irq = s.bo_irq;
  assign irq = s.irq;

endmodule
